// ===== src/eeprom_pkg.sv
// Constants, types and timing for the serial EEPROM command engine.
// Assumes a single 20 MHz system clock and an SPI mode 0 master outside.
package eeprom_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 20_000_000;        // System clock rate
  localparam int unsigned WC_TIME_MS = 5;             // Self-timed write cycle, ms
  localparam int unsigned WC_CYCLES = WC_TIME_MS * (CLK_HZ / 1000); // Write cycle in clocks

  // ==========================================================
  // Array geometry
  // ==========================================================
  localparam int unsigned ADDR_W = 9;                 // 512 bytes
  localparam int unsigned PAGE_BYTES = 8;             // Page write size
  localparam int unsigned FIFO_DEPTH = 32;            // Write data buffer depth

  // ==========================================================
  // Opcodes: upper nibble zero, bit 3 free or address bit nine
  // ==========================================================
  localparam logic [2:0] OP_SET_LATCH = 3'h6;         // set_write_latch_cmd
  localparam logic [2:0] OP_CLR_LATCH = 3'h4;         // clear_write_latch_cmd
  localparam logic [2:0] OP_STAT_RD = 3'h5;           // status_read_cmd
  localparam logic [2:0] OP_STAT_WR = 3'h1;           // status_write_cmd
  localparam logic [2:0] OP_ARR_RD = 3'h3;            // Array read
  localparam logic [2:0] OP_ARR_WR = 3'h2;            // Array write

  // ==========================================================
  // Status layout and protect bounds
  // ==========================================================
  localparam int unsigned ST_BUSY_BIT = 0;            // 1 while writing
  localparam int unsigned ST_WEL_BIT = 1;             // Write latch
  localparam int unsigned ST_PROT_LSB = 2;            // protect_level_lo, _hi at +1
  localparam logic [7:0] ST_BUSY_VAL = 8'hFF;         // Read back during a write cycle
  localparam logic [1:0] PROT_RESET = 2'h0;           // Protect level after reset
  localparam logic [8:0] PROT_Q_BASE = 9'h180;        // Upper quarter start
  localparam logic [8:0] PROT_H_BASE = 9'h100;        // Upper half start

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic [8:0] addr;                                 // Target byte address
    logic [7:0] data;                                 // Byte to program
  } wr_word_t;

  // Frame states, Gray coded along opcode-address-write data
  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_ADDR = 3'b001,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b010,
    ST_SREAD = 3'b110,
    ST_SWDATA = 3'b111,
    ST_DEAD = 3'b101
  } frame_st_t;

endpackage : eeprom_pkg

// ===== src/spi_eeprom_array_access.sv
// SPI mode 0 serial EEPROM command engine with 512-byte array in flip-flops.
// Assumes SCK, chip select, SI and write protect arrive asynchronously and SCK
// runs at no more than one eighth of the system clock.
// Overview of operation
// - Status bit 0 shows write busy
// - Status bit 1 shows write latch
// - Status bits 7..4 zero when idle
// - Status reads all ones while busy
// - Two protect bits select four ranges
// - Protected locations are never programmed
// - Protect update is a latched timed write
// - Read shifts addressed byte out on SO
// - Read address increments and wraps to zero
// - Protect pin or clear latch discards write
// - Busy accepts only status read
// - Programming starts at chip select rise
// - Page write wraps low three bits
// - Finished write clears the latch
// - Opcode decode of six instructions
// - Opcode bit 3 is address bit nine
// - Latch is clear after power-up
// - Bad opcode leaves SO released
`timescale 1ns/1ps

// ==========================================================
// Write data FIFO
// ==========================================================
module wr_fifo #(
  parameter int unsigned WIDTH = 17,                  // Word width
  parameter int unsigned DEPTH = 32                   // Entries
) (
  input wire logic clk_i,                             // System clock
  input wire logic rst_i,                             // Async reset
  input wire logic in_valid_i,                        // Push request
  output logic in_ready_o,                            // Room available
  input wire logic [WIDTH-1:0] in_data_i,             // Pushed word
  output logic out_valid_o,                           // Word available
  input wire logic out_ready_i,                       // Pop request
  output logic [WIDTH-1:0] out_data_o                 // Head word
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];                    // Storage
  logic [PW:0] wr_ptr_r;                              // Extra bit tells full from empty
  logic [PW:0] rd_ptr_r;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {PW{1'b0}}};
  assign out_valid_o = wr_ptr_r != rd_ptr_r;
  assign out_data_o = mem_r[rd_ptr_r[PW-1:0]];

  // Storage needs no reset; pointers define what is valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[PW-1:0]] <= in_data_i;
    end
  end

  // Pointer update
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (PW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (PW+1)'(pop);
    end
  end
endmodule : wr_fifo

// ==========================================================
// Command engine
// ==========================================================
module spi_eeprom_array_access import eeprom_pkg::*; #(
  parameter int unsigned WC_CLKS = WC_CYCLES          // Write cycle length in clocks
) (
  input wire logic ref_clk_i,                         // 20 MHz system clock
  input wire logic rst_i,                             // Async reset, active high
  input wire logic cs_n_i,                            // Chip select, active low
  input wire logic sck_i,                             // Serial clock from master
  input wire logic si_i,                              // Serial data in
  input wire logic wp_n_i,                            // Write protect, active low
  output logic so_o,                                  // Serial data out
  output logic so_oe_o                                // High while SO is driven
);

  // ==========================================================
  // Input synchronisers and edge detection
  // ==========================================================
  logic [3:0] meta_r;                                 // First stage, read only by sync_r
  logic [3:0] sync_r;                                 // {wp_n, si, sck, cs_n}
  logic sck_d_r;                                      // Previous SCK sample
  logic cs_d_r;                                       // Previous chip select sample

  // Two flops per pin; edges come from the second stage only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 4'h9;
      sync_r <= 4'h9;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      meta_r <= {wp_n_i, si_i, sck_i, cs_n_i};
      sync_r <= meta_r;
      sck_d_r <= sync_r[1];
      cs_d_r <= sync_r[0];
    end
  end

  wire cs_n_s = sync_r[0];
  wire si_s = sync_r[2];
  wire wp_ok = sync_r[3];
  wire selected = ~cs_n_s;
  wire cs_fall = cs_d_r & ~cs_n_s;
  wire cs_rise = ~cs_d_r & cs_n_s;
  // sample on rise, shift on fall
  wire sck_rise = selected & sync_r[1] & ~sck_d_r;
  wire sck_fall = selected & ~sync_r[1] & sck_d_r;

  // ==========================================================
  // State
  // ==========================================================
  frame_st_t state_r;                                 // Frame phase
  logic [2:0] bit_cnt_r;                              // Bits taken in current byte
  logic [6:0] rx_sh_r;                                // Incoming shift register
  logic [8:0] addr_r;                                 // Working byte address
  logic is_read_r;                                    // Address phase leads to read
  logic [7:0] tx_byte_r;                              // Byte being shifted out
  logic wel_r;                                        // Write-enable latch
  logic got_byte_r;                                   // At least one data byte in frame
  logic wr_pend_r;                                    // Array write awaiting start
  logic sw_pend_r;                                    // Protect write awaiting start
  logic [1:0] bp_new_r;                               // Protect bits from status write
  logic [1:0] bp_r;                                   // Stored protect level
  logic busy_r;                                       // Write cycle running
  logic [16:0] wc_cnt_r;                              // Write cycle timer
  logic so_r;
  logic so_oe_r;
  logic [7:0] mem_r [1 << ADDR_W];                    // Nonvolatile array, no reset
  logic [7:0] pg_data_r [PAGE_BYTES];                 // Page staging data
  logic [PAGE_BYTES-1:0] pg_val_r;                    // Staged entries
  logic [5:0] pg_base_r;                              // Page number

  // ==========================================================
  // Decode
  // ==========================================================
  wire [7:0] rx_byte = {rx_sh_r, si_s};
  wire byte_done = sck_rise & (bit_cnt_r == 3'h7);
  wire fifo_empty;
  wire start_prog = (wr_pend_r | sw_pend_r) & fifo_empty & ~busy_r;
  wire wc_done = busy_r & (wc_cnt_r == 17'(WC_CLKS - 1));
  wire [8:0] addr_inc = addr_r + 9'h001;
  wire [2:0] opc_low = rx_byte[2:0];
  wire opc_legal = rx_byte[7:4] == 4'h0;
  wire [7:0] status_idle = {4'h0, bp_r, wel_r, 1'b0};
  wire [7:0] status_val = busy_r ? ST_BUSY_VAL : status_idle;
  wire write_ok = wel_r & wp_ok;
  wire reading = (state_r == ST_RDATA) | (state_r == ST_SREAD);

  function automatic logic is_prot(input logic [1:0] lvl, input logic [8:0] a);
    is_prot = (lvl == 2'h3) | ((lvl == 2'h2) & (a >= PROT_H_BASE)) |
              ((lvl == 2'h1) & (a >= PROT_Q_BASE));
  endfunction : is_prot

  // FIFO in the write data path; drain stalls during a write cycle
  wr_word_t push_word;
  wr_word_t pop_word;
  wire push_ready;
  wire pop_valid;
  wire push_valid = byte_done & (state_r == ST_WDATA) & wp_ok;
  assign push_word = '{addr: addr_r, data: rx_byte};

  wr_fifo #(.WIDTH($bits(wr_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_word),
    .out_valid_o(pop_valid),
    .out_ready_i(~busy_r),
    .out_data_o(pop_word)
  );
  assign fifo_empty = ~pop_valid;

  // ==========================================================
  // Frame sequencer
  // ==========================================================
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_OPC;
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
      addr_r <= 9'h000;
      is_read_r <= 1'b0;
      tx_byte_r <= 8'h00;
      got_byte_r <= 1'b0;
      wr_pend_r <= 1'b0;
      sw_pend_r <= 1'b0;
      bp_new_r <= PROT_RESET;
      wel_r <= 1'b0;
    end else begin
      // latch cleared at end of write
      if (wc_done) begin
        wel_r <= 1'b0;
      end
      if (start_prog) begin
        wr_pend_r <= 1'b0;
        sw_pend_r <= 1'b0;
      end
      if (cs_fall) begin
        state_r <= ST_OPC;
        bit_cnt_r <= 3'h0;
        got_byte_r <= 1'b0;
      end else if (cs_rise) begin
        // start only at chip select rise on a byte boundary
        if (state_r == ST_WDATA && bit_cnt_r == 3'h0 && got_byte_r) begin
          wr_pend_r <= 1'b1;
        end
        // protect update runs as a write cycle
        if (state_r == ST_SWDATA && bit_cnt_r == 3'h0 && got_byte_r) begin
          sw_pend_r <= 1'b1;
        end
        state_r <= ST_OPC;
      end else if ((state_r == ST_WDATA || state_r == ST_SWDATA) && !wp_ok) begin
        // protect pin low interrupts the write
        state_r <= ST_DEAD;
      end else if (sck_rise && state_r != ST_DEAD) begin
        rx_sh_r <= rx_byte[6:0];
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (byte_done) begin
          unique case (state_r)
            ST_OPC: begin
              addr_r[8] <= rx_byte[3];
              tx_byte_r <= status_val;
              state_r <= ST_DEAD;
              if (!opc_legal) begin
                state_r <= ST_DEAD;
              end else if (busy_r && opc_low != OP_STAT_RD) begin
                state_r <= ST_DEAD;
              end else if (opc_low == OP_SET_LATCH) begin
                wel_r <= wp_ok;
              end else if (opc_low == OP_CLR_LATCH) begin
                wel_r <= 1'b0;
              end else if (opc_low == OP_STAT_RD) begin
                state_r <= ST_SREAD;
              end else if (opc_low == OP_STAT_WR) begin
                state_r <= write_ok ? ST_SWDATA : ST_DEAD;
              end else if (opc_low == OP_ARR_RD) begin
                is_read_r <= 1'b1;
                state_r <= ST_ADDR;
              end else if (opc_low == OP_ARR_WR) begin
                // write discarded without latch or pin
                is_read_r <= 1'b0;
                state_r <= write_ok ? ST_ADDR : ST_DEAD;
              end
            end
            ST_ADDR: begin
              // opcode bit 3 already in addr_r[8]
              addr_r[7:0] <= rx_byte;
              tx_byte_r <= mem_r[{addr_r[8], rx_byte}];
              state_r <= is_read_r ? ST_RDATA : ST_WDATA;
            end
            ST_RDATA: begin
              addr_r <= addr_inc;
              tx_byte_r <= mem_r[addr_inc];
            end
            ST_SREAD: begin
              tx_byte_r <= status_val;
            end
            ST_WDATA: begin
              // only the low three bits advance
              addr_r[2:0] <= addr_r[2:0] + 3'h1;
              got_byte_r <= 1'b1;
              if (!push_ready) begin
                state_r <= ST_DEAD;
              end
            end
            ST_SWDATA: begin
              // new protect bits from bits 3 and 2
              bp_new_r <= rx_byte[3:2];
              got_byte_r <= 1'b1;
            end
            ST_DEAD: begin
              state_r <= ST_DEAD;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Serial output
  // ==========================================================
  // data shifted out after falling SCK
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      so_oe_r <= selected & reading;
      if (sck_fall && reading) begin
        so_r <= tx_byte_r[3'h7 - bit_cnt_r];
      end
    end
  end
  assign so_o = so_r;
  assign so_oe_o = so_oe_r;

  // ==========================================================
  // Page staging, fed from the FIFO
  // ==========================================================
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pg_val_r <= '0;
      pg_base_r <= 6'h00;
    end else if (start_prog) begin
      pg_val_r <= '0;
    end else if (cs_fall && !wr_pend_r) begin
      // drop unclosed frame bytes
      // A frame killed by the protect pin leaves staged bytes behind
      pg_val_r <= '0;
    end else if (pop_valid && !busy_r) begin
      // Later bytes for the same slot overwrite earlier ones
      pg_val_r[pop_word.addr[2:0]] <= 1'b1;
      pg_base_r <= pop_word.addr[8:3];
    end
  end

  // Staging data needs no reset; pg_val_r qualifies it
  always_ff @(posedge ref_clk_i) begin
    if (pop_valid && !busy_r) begin
      pg_data_r[pop_word.addr[2:0]] <= pop_word.data;
    end
  end

  // ==========================================================
  // Write cycle timer and array programming
  // ==========================================================
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      wc_cnt_r <= 17'h00000;
      bp_r <= PROT_RESET;
    end else if (start_prog) begin
      busy_r <= 1'b1;
      wc_cnt_r <= 17'h00000;
      if (sw_pend_r) begin
        bp_r <= bp_new_r;
      end
    end else if (wc_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      wc_cnt_r <= wc_cnt_r + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (start_prog && wr_pend_r) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pg_val_r[i] && !is_prot(bp_r, {pg_base_r, 3'(i)})) begin
          mem_r[{pg_base_r, 3'(i)}] <= pg_data_r[i];
        end
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  busy_ones_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (busy_r && byte_done && state_r == ST_OPC && !cs_fall && !cs_rise) |=>
    tx_byte_r == 8'hFF) else $error("status not all ones while busy");
  idle_bits_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!busy_r && byte_done && state_r == ST_OPC && !cs_fall && !cs_rise) |=>
    (tx_byte_r[7:4] == 4'h0) && !tx_byte_r[0])
    else $error("idle status high bits or busy bit set");
  wel_bit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!busy_r && byte_done && state_r == ST_OPC && !cs_fall && !cs_rise) |=>
    tx_byte_r[1] == $past(wel_r)) else $error("status latch bit wrong");
  latch_clr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(busy_r) |-> !wel_r) else $error("latch still set after write");
  prog_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(busy_r) |-> $past(wr_pend_r) || $past(sw_pend_r))
    else $error("write cycle began without a closed frame");
  busy_ignore_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (busy_r && byte_done && state_r == ST_OPC && opc_low != OP_STAT_RD && !cs_fall && !cs_rise)
    |=> state_r == ST_DEAD) else $error("command accepted while busy");
  page_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (push_valid && push_ready && !cs_fall && !cs_rise) |=>
    addr_r == {$past(addr_r[8:3]), $past(addr_r[2:0]) + 3'h1})
    else $error("page address left its page");
  quarter_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (bp_r == 2'h1) |-> (is_prot(bp_r, addr_r) == (addr_r >= 9'h180)))
    else $error("quarter protect bound wrong");
  rd_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (byte_done && state_r == ST_RDATA && addr_r == 9'h1FF && !cs_fall && !cs_rise)
    |=> addr_r == 9'h000) else $error("read address did not wrap");
  dead_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ST_DEAD) [*2] |-> !so_oe_o) else $error("SO driven after bad opcode");

endmodule : spi_eeprom_array_access

// ===== bench/spi_master_model.sv
// SPI mode 0 master model that drives the EEPROM pins from tasks.
// Assumes the bench resolves the SO wire and shares the system clock.
`timescale 1ns/1ps
module spi_master_model (
  input wire logic clk_i, // System clock
  input wire logic so_i, // Resolved SO wire
  output logic cs_n_o, // Chip select, active low
  output logic sck_o, // Serial clock
  output logic si_o, // Serial data out to device
  output logic got_o, // Strobe for a checked byte
  output logic [7:0] got_byte_o // Byte taken from SO
);
  // ==========
  // Idle pins: deselected, SCK parked low between frames
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    got_o = 1'b0;
    got_byte_o = 8'h00;
  end
  // Wait a number of system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // Start a frame
  task automatic sel();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    tick(4);
  endtask : sel
  // MSB first, mode 0
  // Half period of four clocks gives the 400 ns link clock
  task automatic xfer(input logic [7:0] tx, input logic chk, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_o <= tx[i];
      tick(4);
      sck_o <= 1'b1;
      rx[i] = so_i;
      tick(4);
      sck_o <= 1'b0;
    end
    got_byte_o <= rx;
    got_o <= chk;
    tick(1);
    got_o <= 1'b0;
  endtask : xfer
  task automatic desel();
    cs_n_o <= 1'b1;
    tick(8);
  endtask : desel
endmodule : spi_master_model

// ===== bench/spi_eeprom_array_access_bench.sv
// Self-checking bench for the SPI EEPROM command engine.
// Assumes the master model drives the link; a short write cycle is used.
`timescale 1ns/1ps
`define CHK(a, b, m) begin \
  n_checks++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, a, b); \
  end \
end
module spi_eeprom_array_access_bench import eeprom_pkg::*;;
  localparam int unsigned WC = 400; // Short write cycle in clocks
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n_i = 1'b1;
  logic cs_n, sck, si, so, so_oe, got;
  logic so_last = 1'b0; // Last wire level, inverted when released
  logic [7:0] got_byte, rx, e;
  logic [1:0] lvl = 2'h0; // Expected protect level
  logic [7:0] mem [512]; // Reference array
  logic [7:0] exp_q [$]; // Expected SO bytes
  int bad_count = 0;
  int n_checks = 0;
  int seed = 32'h4232;
  // Released SO toggles so a stale value never passes
  wire so_w = so_oe ? so : ~so_last;
  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) so_last <= so_w;
  spi_eeprom_array_access #(.WC_CLKS(WC)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe));
  spi_master_model i_master (.clk_i(ref_clk_i), .so_i(so_w), .cs_n_o(cs_n), .sck_o(sck),
    .si_o(si), .got_o(got), .got_byte_o(got_byte));
  // ==========
  // Monitor: oldest note against each byte seen
  always @(posedge ref_clk_i) begin
    if (got === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : ~got_byte;
      `CHK(got_byte, e, "so byte")
    end
  end
  function automatic logic prot(input logic [8:0] a);
    return (lvl == 2'h3) || (lvl == 2'h2 && a[8]) || (lvl == 2'h1 && a[8:7] == 2'h3);
  endfunction : prot
  task automatic op(input logic [7:0] b);
    i_master.sel();
    i_master.xfer(b, 1'b0, rx);
    i_master.desel();
  endtask : op
  task automatic stat(input logic [7:0] x, input logic chk);
    i_master.sel();
    i_master.xfer({5'h00, OP_STAT_RD}, 1'b0, rx);
    if (chk) exp_q.push_back(x);
    i_master.xfer(8'($random(seed)), chk, rx);
    i_master.desel();
  endtask : stat
  task automatic poll();
    rx = 8'hFF;
    repeat (20) if (rx[0] !== 1'b0) stat(8'h00, 1'b0);
    `CHK(rx[0], 1'b0, "write never ended")
  endtask : poll
  // ==========
  // Page write; the note keeps only bytes the device may program
  task automatic wr(input logic [8:0] a, input int n, input logic ok);
    logic [7:0] d;
    i_master.sel();
    i_master.xfer({4'h0, a[8], OP_ARR_WR}, 1'b0, rx);
    i_master.xfer(a[7:0], 1'b0, rx);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      if (ok && !prot(a)) mem[a] = d;
      i_master.xfer(d, 1'b0, rx);
      a[2:0] = a[2:0] + 3'h1;
    end
    i_master.desel();
  endtask : wr
  task automatic rd(input logic [8:0] a, input int n);
    i_master.sel();
    i_master.xfer({4'h0, a[8], OP_ARR_RD}, 1'b0, rx);
    i_master.xfer(a[7:0], 1'b0, rx);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[a]);
      i_master.xfer(8'($random(seed)), 1'b1, rx);
      a = a + 9'h001;
    end
    i_master.desel();
  endtask : rd
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // ==========
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    stat(8'h00, 1'b1);
    wr(9'h010, 2, 1'b0);
    stat(8'h00, 1'b1);
    op({5'h00, OP_SET_LATCH});
    stat(8'h02, 1'b1);
    op({5'h00, OP_CLR_LATCH});
    stat(8'h00, 1'b1);
    op({5'h00, OP_SET_LATCH});
    wp_n_i <= 1'b0;
    wr(9'h010, 2, 1'b0);
    wp_n_i <= 1'b1;
    stat(8'h02, 1'b1);
    $display("test latch done");
    wr(9'h1FE, 10, 1'b1);
    stat(8'hFF, 1'b1);
    op({5'h00, OP_SET_LATCH});
    poll();
    stat(8'h00, 1'b1);
    op({5'h00, OP_SET_LATCH});
    wr(9'h000, 8, 1'b1);
    poll();
    $display("test page done");
    op({5'h00, OP_SET_LATCH});
    op({5'h00, OP_STAT_WR} | 8'h00);
    op({5'h00, OP_SET_LATCH});
    i_master.sel();
    i_master.xfer({5'h00, OP_STAT_WR}, 1'b0, rx);
    i_master.xfer(8'hF7, 1'b0, rx);
    i_master.desel();
    lvl = 2'h1;
    stat(8'hFF, 1'b1);
    poll();
    stat(8'h04, 1'b1);
    op({5'h00, OP_SET_LATCH});
    wr(9'h1F8, 8, 1'b1);
    poll();
    op({5'h00, OP_SET_LATCH});
    wr(9'h000, 3, 1'b1);
    poll();
    rd(9'h1F8, 10);
    $display("test protect done");
    i_master.sel();
    i_master.xfer(8'hF5, 1'b0, rx);
    i_master.xfer(8'($random(seed)), 1'b0, rx);
    `CHK(so_oe, 1'b0, "so driven after bad opcode")
    i_master.desel();
    `CHK(exp_q.size(), 0, "bytes missing")
    $display("test opcode done");
    end_sim();
  end
  // Watchdog well past the expected run length
  initial begin
    #2000000;
    bad_count++;
    end_sim();
  end
endmodule : spi_eeprom_array_access_bench
